// ### irq_flag_map.vh
// register map, field positions and reset values of the interrupt flag block
`ifndef IRQ_FLAG_MAP_VH
`define IRQ_FLAG_MAP_VH

`define ADDR_IRQ_CLEAR 32'h00003004
`define ADDR_IRQ_SELECT0 32'h00003008
`define ADDR_IRQ_SELECT1 32'h0000300C
`define ADDR_IRQ_FLAGS0 32'h00003010
`define ADDR_IRQ_FLAGS1 32'h00003014
`define ADDR_IRQ_PENDING 32'h00003018
`define ADDR_IRQ_SOURCES 32'h0000301C

`define ADDR_WORD_HI 31
`define ADDR_WORD_LO 2

`define RESET_FLAGS 32'h00000000
`define RESET_SELECT 32'h00002000
`define RESET_ZERO 32'h00000000

`define BIT_SEQ_COLLISION 31
`define BIT_OUTLIER 29
`define BIT_FIFO_UNDERFLOW 27
`define BIT_FIFO_OVERFLOW 26
`define BIT_FIFO_THRESHOLD 25
`define BIT_FIFO_EMPTY 24
`define BIT_FIFO_FULL 23
`define BIT_SEQ_TIMEOUT_ERROR 17
`define BIT_SEQ_TIMEOUT_DONE 16
`define BIT_END_OF_SEQUENCE 15
`define BIT_BOOT_DONE 13
`define BIT_CUSTOM_IRQ3 12

`define BIT_RESERVED_HI 30
`define BIT_RESERVED_MID 28
`define FIELD_RESERVED_HI 22
`define FIELD_RESERVED_LO 18
`define BIT_RESERVED_LO 14
`define FIELD_LOWER_HI 11
`define FIELD_LOWER_LO 0

`define FLAG_IMPL_MASK 32'hAF83B000

`define HTRANS_NONSEQ_BIT 1
`define HSIZE_WORD 3'h2
`define HRESP_OKAY 1'h0

`endif

// ### irq_flag_group.v
// one group of sticky interrupt flags with its enable gating
`timescale 1ns/100ps
`include "irq_flag_map.vh"
module irq_flag_group #(
  parameter WIDTH = 32,
  parameter [WIDTH-1:0] IMPL_MASK = `FLAG_IMPL_MASK,
  parameter [WIDTH-1:0] RESET_VALUE = `RESET_FLAGS
) (
  input wire hclk,
  input wire hresetn,
  input wire [WIDTH-1:0] set_events,
  input wire [WIDTH-1:0] clear_bits,
  input wire [WIDTH-1:0] enable_bits,
  output reg [WIDTH-1:0] flags,
  output wire [WIDTH-1:0] pending
);

  wire [WIDTH-1:0] next_flags;

  // set wins over clear so an event in the clearing cycle is kept
  assign next_flags = ((flags & ~clear_bits) | set_events) & IMPL_MASK;

  // reserved positions are masked and therefore always read zero
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flags <= RESET_VALUE;
    end else begin
      flags <= next_flags;
    end
  end

  assign pending = flags & enable_bits;

endmodule // irq_flag_group

// ### irq_flag_status.v
// interrupt flag status block: two flag groups behind an ahb-lite slave
//
// Function
// - two read-only flag registers, same layout, reset to zero, at 0x3010/0x3014.
// - bit 31 sets when sequence b requested while a runs; b ignored.
// - bits 27..23 flag fifo underflow, overflow, threshold, empty, full.
// - bits 17, 16, 15 flag timeout error, timeout done, end of sequence.
// - bit 13 boot done, bit 29 outlier; reserved bits read zero.
// - bit 12 flags custom interrupt 3, resets to zero.
// - writing one to the clear register drops that flag; zero does nothing.
`timescale 1ns/100ps
`include "irq_flag_map.vh"
module irq_flag_status #(
  parameter WIDTH = 32
) (
  input wire hclk,
  input wire hresetn,
  // ahb-lite slave
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire hready,
  input wire [31:0] hwdata,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  // interrupt sources, levels synchronous to hclk
  input wire seq_a_running,
  input wire seq_b_request,
  input wire outlier_event,
  input wire fifo_underflow_event,
  input wire fifo_overflow_event,
  input wire fifo_threshold_event,
  input wire fifo_empty_event,
  input wire fifo_full_event,
  input wire seq_timeout_error_event,
  input wire seq_timeout_done_event,
  input wire end_of_sequence_event,
  input wire boot_done_event,
  input wire custom_irq3_event,
  // results
  output reg seq_b_start,
  output reg irq
);

  // data phase tracker, one-hot; an illegal code falls back to idle
  localparam [1:0] PHASE_IDLE = 2'b01;
  localparam [1:0] PHASE_WRITE = 2'b10;
  reg [1:0] phase;
  reg [1:0] next_phase;

  // address phase capture
  reg [31:0] wr_addr;
  wire addr_phase;
  wire word_size;
  wire wr_request;
  wire rd_request;
  wire wr_pending;
  wire wr_clear;

  // register state
  reg [WIDTH-1:0] select0;
  reg [WIDTH-1:0] select1;
  reg [WIDTH-1:0] next_select0;
  reg [WIDTH-1:0] next_select1;
  reg [WIDTH-1:0] clear_bits;
  reg [31:0] next_hrdata;

  // flag groups
  wire [WIDTH-1:0] irq_flags_group0;
  wire [WIDTH-1:0] irq_flags_group1;
  wire [WIDTH-1:0] pending0;
  wire [WIDTH-1:0] pending1;
  wire [WIDTH-1:0] set_events;
  wire [WIDTH-1:0] source_levels;
  wire sequence_collision;
  wire any_pending0;
  wire any_pending1;
  wire next_irq;

  // ahb-lite decode
  assign addr_phase = hsel & hready & htrans[`HTRANS_NONSEQ_BIT];
  // narrow writes are dropped: a byte lane write would clobber the word
  assign word_size = (hsize == `HSIZE_WORD);
  assign wr_request = addr_phase & hwrite & word_size;
  assign rd_request = addr_phase & ~hwrite;
  assign wr_pending = (phase == PHASE_WRITE);

  // a write owns the cycle after its address phase; reads need no state
  always @* begin
    next_phase = PHASE_IDLE;
    case (phase)
      PHASE_IDLE: begin
        if (wr_request) begin
          next_phase = PHASE_WRITE;
        end
      end
      PHASE_WRITE: begin
        if (wr_request) begin
          next_phase = PHASE_WRITE;
        end
      end
      default: begin
        next_phase = PHASE_IDLE;
      end
    endcase
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      phase <= PHASE_IDLE;
      wr_addr <= `RESET_ZERO;
    end else begin
      phase <= next_phase;
      if (wr_request) begin
        wr_addr <= haddr;
      end
    end
  end

  // the slave never stalls and always answers okay
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'h1;
      hresp <= `HRESP_OKAY;
    end else begin
      hreadyout <= 1'h1;
      hresp <= `HRESP_OKAY;
    end
  end

  // collision: a second sequence asked for while the first still runs
  assign sequence_collision = seq_b_request & seq_a_running;

  // the ignored request never reaches the sequencer start
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      seq_b_start <= 1'h0;
    end else begin
      seq_b_start <= seq_b_request & ~seq_a_running;
    end
  end

  // source levels placed at their flag positions
  assign source_levels[`BIT_SEQ_COLLISION] = sequence_collision;
  assign source_levels[`BIT_RESERVED_HI] = 1'h0;
  assign source_levels[`BIT_OUTLIER] = outlier_event;
  assign source_levels[`BIT_RESERVED_MID] = 1'h0;
  assign source_levels[`BIT_FIFO_UNDERFLOW] = fifo_underflow_event;
  assign source_levels[`BIT_FIFO_OVERFLOW] = fifo_overflow_event;
  assign source_levels[`BIT_FIFO_THRESHOLD] = fifo_threshold_event;
  assign source_levels[`BIT_FIFO_EMPTY] = fifo_empty_event;
  assign source_levels[`BIT_FIFO_FULL] = fifo_full_event;
  assign source_levels[`FIELD_RESERVED_HI:`FIELD_RESERVED_LO] = 5'h00;
  assign source_levels[`BIT_SEQ_TIMEOUT_ERROR] = seq_timeout_error_event;
  assign source_levels[`BIT_SEQ_TIMEOUT_DONE] = seq_timeout_done_event;
  assign source_levels[`BIT_END_OF_SEQUENCE] = end_of_sequence_event;
  assign source_levels[`BIT_RESERVED_LO] = 1'h0;
  assign source_levels[`BIT_BOOT_DONE] = boot_done_event;
  assign source_levels[`BIT_CUSTOM_IRQ3] = custom_irq3_event;
  // lower sources live in another block and read zero here
  assign source_levels[`FIELD_LOWER_HI:`FIELD_LOWER_LO] = 12'h000;

  // a source held high keeps setting its flag, so a clear only sticks
  // once the source has gone low
  assign set_events = source_levels & `FLAG_IMPL_MASK;

  // write one to clear, one cycle wide, both groups at once
  assign wr_clear = wr_pending & (wr_addr == `ADDR_IRQ_CLEAR);
  always @* begin
    clear_bits = `RESET_ZERO;
    if (wr_clear) begin
      clear_bits = hwdata;
    end
  end

  // enable registers, read and write
  always @* begin
    next_select0 = select0;
    next_select1 = select1;
    if (wr_pending) begin
      case (wr_addr)
        `ADDR_IRQ_SELECT0: begin
          next_select0 = hwdata;
        end
        `ADDR_IRQ_SELECT1: begin
          next_select1 = hwdata;
        end
        default: begin
          next_select0 = select0;
          next_select1 = select1;
        end
      endcase
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      select0 <= `RESET_SELECT;
      select1 <= `RESET_SELECT;
    end else begin
      select0 <= next_select0;
      select1 <= next_select1;
    end
  end

  irq_flag_group #(
    .WIDTH(WIDTH),
    .IMPL_MASK(`FLAG_IMPL_MASK),
    .RESET_VALUE(`RESET_FLAGS)
  ) u_group0 (
    .hclk(hclk),
    .hresetn(hresetn),
    .set_events(set_events),
    .clear_bits(clear_bits),
    .enable_bits(select0),
    .flags(irq_flags_group0),
    .pending(pending0)
  );

  irq_flag_group #(
    .WIDTH(WIDTH),
    .IMPL_MASK(`FLAG_IMPL_MASK),
    .RESET_VALUE(`RESET_FLAGS)
  ) u_group1 (
    .hclk(hclk),
    .hresetn(hresetn),
    .set_events(set_events),
    .clear_bits(clear_bits),
    .enable_bits(select1),
    .flags(irq_flags_group1),
    .pending(pending1)
  );

  // one level output for both groups
  assign any_pending0 = |pending0;
  assign any_pending1 = |pending1;
  assign next_irq = any_pending0 | any_pending1;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq <= 1'h0;
    end else begin
      irq <= next_irq;
    end
  end

  // read data chosen in the address phase, presented in the data phase;
  // writes to the flag registers are dropped since they are read-only
  always @* begin
    next_hrdata = `RESET_ZERO;
    case (haddr)
      `ADDR_IRQ_CLEAR: begin
        next_hrdata = `RESET_ZERO;
      end
      `ADDR_IRQ_SELECT0: begin
        next_hrdata = select0;
      end
      `ADDR_IRQ_SELECT1: begin
        next_hrdata = select1;
      end
      `ADDR_IRQ_FLAGS0: begin
        next_hrdata = irq_flags_group0;
      end
      `ADDR_IRQ_FLAGS1: begin
        next_hrdata = irq_flags_group1;
      end
      `ADDR_IRQ_PENDING: begin
        next_hrdata = pending0 | pending1;
      end
      `ADDR_IRQ_SOURCES: begin
        next_hrdata = source_levels;
      end
      default: begin
        next_hrdata = `RESET_ZERO;
      end
    endcase
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= `RESET_ZERO;
    end else if (rd_request) begin
      hrdata <= next_hrdata;
    end
  end

endmodule // irq_flag_status

// ### irq_flag_status_props.sv
// assertion checker for the interrupt flag status block
`timescale 1ns/100ps
module irq_flag_status_props (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire hready,
  input wire [31:0] hrdata,
  input wire hreadyout,
  input wire hresp,
  input wire seq_a_running,
  input wire seq_b_request,
  input wire boot_done_event,
  input wire custom_irq3_event,
  input wire seq_b_start,
  input wire irq
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  wire rd = hsel && hready && htrans[1] && !hwrite;
  wire rd_f0 = rd && haddr == 32'h00003010;
  sequence boot_then_read;
    boot_done_event ##1 rd_f0;
  endsequence
  sequence c3_then_read;
    custom_irq3_event ##1 rd_f0;
  endsequence
  bus_okay_a: assert property (hreadyout && !hresp)
    else $error("bus answer not ready or not okay");
  collide_block_a: assert property (seq_b_request && seq_a_running |=> !seq_b_start)
    else $error("second sequence started while first runs");
  start_pass_a: assert property (seq_b_request && !seq_a_running |=> seq_b_start)
    else $error("second sequence not started");
  reserved_zero_a: assert property (rd_f0 |=> (hrdata & 32'h507C4FFF) == 32'h0)
    else $error("reserved flag bit reads one");
  boot_sticky_a: assert property (boot_then_read |=> hrdata[13])
    else $error("boot done flag missing");
  custom3_flag_a: assert property (c3_then_read |=> hrdata[12])
    else $error("custom flag missing");
  irq_follow_a: assert property (boot_done_event |-> ##2 irq)
    else $error("irq not raised after enabled flag");
  read_hold_a: assert property (!rd |=> $stable(hrdata))
    else $error("read data changed without a read");
  unmapped_zero_a: assert property (rd && haddr == 32'h00003020 |=> hrdata == 32'h0)
    else $error("unmapped read not zero");
endmodule // irq_flag_status_props

// ### testbench.sv
// self-checking bench for the interrupt flag status block
`timescale 1ns/100ps
`include "irq_flag_map.vh"
module testbench;
  localparam [31:0] impl = 32'hAF83B000;
  reg hclk, hresetn, hsel, hwrite, seq_a;
  reg [1:0] htrans;
  reg [31:0] haddr, hwdata, ev, d;
  wire [31:0] hrdata;
  wire hreadyout, hresp, seq_b_start, irq;
  integer errors, comparisons, b;
  irq_flag_status DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .seq_a_running(seq_a),
    .seq_b_request(ev[31]), .outlier_event(ev[29]),
    .fifo_underflow_event(ev[27]), .fifo_overflow_event(ev[26]),
    .fifo_threshold_event(ev[25]), .fifo_empty_event(ev[24]),
    .fifo_full_event(ev[23]), .seq_timeout_error_event(ev[17]),
    .seq_timeout_done_event(ev[16]), .end_of_sequence_event(ev[15]),
    .boot_done_event(ev[13]), .custom_irq3_event(ev[12]),
    .seq_b_start(seq_b_start), .irq(irq));
  task wait_ready;
    begin
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
    end
  endtask
  task bus(input w, input [31:0] a, input [31:0] wd);
    begin
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= w;
      htrans <= 2'h2;
      wait_ready;
      htrans <= 2'h0;
      hwdata <= wd;
      wait_ready;
      d = hrdata;
    end
  endtask
  task cmp(input [31:0] got, input [31:0] exp);
    begin
      comparisons = comparisons + 1;
      if (got !== exp) begin
        errors = errors + 1;
        $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task chk(input [31:0] a, input [31:0] exp);
    begin
      bus(1'b0, a, 32'h0);
      cmp(d, exp);
    end
  endtask
  task irq_is(input v);
    begin
      @(posedge hclk);
      #1;
      cmp({31'h0, irq}, {31'h0, v});
    end
  endtask
  task start_is(input v);
    begin
      @(posedge hclk);
      #1;
      cmp({31'h0, seq_b_start}, {31'h0, v});
    end
  endtask
  task pulse(input integer n);
    begin
      @(posedge hclk);
      ev[n] <= 1'b1;
      @(posedge hclk);
      ev[n] <= 1'b0;
      @(posedge hclk);
    end
  endtask
  task finish_test;
    begin
      $display("comparisons %0d errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end
  // run needs about 364 cycles; far above that means a hang
  initial begin
    #200000;
    errors = errors + 1;
    finish_test;
  end
  initial begin
    errors = 0;
    comparisons = 0;
    {hresetn, hsel, hwrite, seq_a, htrans} = 6'h0;
    {haddr, hwdata, ev, d} = 128'h0;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    chk(`ADDR_IRQ_FLAGS0, 32'h0);
    chk(`ADDR_IRQ_FLAGS1, 32'h0);
    chk(`ADDR_IRQ_SELECT0, 32'h00002000);
    bus(1'b1, `ADDR_IRQ_FLAGS0, 32'hFFFFFFFF);
    bus(1'b1, `ADDR_IRQ_FLAGS1, 32'hFFFFFFFF);
    chk(`ADDR_IRQ_FLAGS0, 32'h0);
    chk(`ADDR_IRQ_FLAGS1, 32'h0);
    chk(32'h00003020, 32'h0);
    $display("test reset and read-only done");
    // first sequence running so that a second request collides
    seq_a <= 1'b1;
    for (b = 0; b < 32; b = b + 1) begin
      if (impl[b]) begin
        pulse(b);
        chk(`ADDR_IRQ_FLAGS0, 32'h1 << b);
        chk(`ADDR_IRQ_FLAGS1, 32'h1 << b);
        bus(1'b1, `ADDR_IRQ_CLEAR, 32'h0);
        chk(`ADDR_IRQ_FLAGS0, 32'h1 << b);
        bus(1'b1, `ADDR_IRQ_CLEAR, 32'h1 << b);
        chk(`ADDR_IRQ_FLAGS0, 32'h0);
        chk(`ADDR_IRQ_FLAGS1, 32'h0);
      end
    end
    // a colliding request must not start the second sequence
    @(posedge hclk);
    ev[31] <= 1'b1;
    start_is(1'b0);
    @(posedge hclk);
    ev[31] <= 1'b0;
    bus(1'b1, `ADDR_IRQ_CLEAR, 32'h80000000);
    seq_a <= 1'b0;
    @(posedge hclk);
    ev[31] <= 1'b1;
    start_is(1'b1);
    @(posedge hclk);
    ev[31] <= 1'b0;
    start_is(1'b0);
    chk(`ADDR_IRQ_FLAGS0, 32'h0);
    $display("test flag set and clear done");
    @(posedge hclk);
    ev <= 32'h00003000;
    chk(`ADDR_IRQ_FLAGS0, 32'h00003000);
    ev <= 32'h0;
    irq_is(1'b1);
    bus(1'b1, `ADDR_IRQ_SELECT0, 32'h0);
    bus(1'b1, `ADDR_IRQ_SELECT1, 32'h0);
    irq_is(1'b0);
    bus(1'b1, `ADDR_IRQ_SELECT1, 32'h00002000);
    irq_is(1'b1);
    bus(1'b1, `ADDR_IRQ_CLEAR, 32'h00003000);
    irq_is(1'b0);
    chk(`ADDR_IRQ_FLAGS1, 32'h0);
    $display("test interrupt output done");
    finish_test;
  end
endmodule // testbench
bind irq_flag_status irq_flag_status_props props (.hclk(hclk),
  .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .seq_a_running(seq_a_running),
  .seq_b_request(seq_b_request), .boot_done_event(boot_done_event),
  .custom_irq3_event(custom_irq3_event), .seq_b_start(seq_b_start),
  .irq(irq));
